/* include/hw_monitor_pkg.sv */
// constants, types and register map of the host error and value register bank
// Contract
// - regulator-hot input sets status1 bit 4
// - voltage 1-4 window errors set status2 bits
// - voltage 5, analog 13-16 errors set status3
// - diode open/short faults set status4 bits
// - general input 8 sets bit3, legacy mode
// - core voltage mismatch sets status4 bit 4
// - any throttling sets throttle status bit 0
// - throttle fraction bins set bits 1-5
// - full throttle bit6, over user limit bit7
// - only user-limit throttle bit feeds summary
// - low general input sets bit unless masked
// - slow fan tach sets fan bits 0-3
// - zone4 host-writable or taken from voltage reading 7
// - zone 1/2 temperature reads 80h on fault
// - filtered registers hold smoothed zone temperatures
// - voltage readings scaled, nominal reads C0h
// - current throttle loads n/256 each interval
// - write to current throttle restarts capture
// - any nonzero throttle time reads at least one
// - average throttle is (previous plus current)/2
// - clear fails while condition still present
// - events suppressed in listed sleep states
// - live state shows one per low input
`default_nettype none
package hw_monitor_pkg;
  // defaults for top-level parameters (address value is arbitrary)
  localparam logic [6:0] SLAVE_ADDR_DEF    = 7'h2c;
  localparam int         THR_TICK_LOG2_DEF = 6;
  localparam logic [3:0] BYTE_BITS         = 4'h8;
  // status register set
  localparam int NUM_STAT = 7;
  typedef logic [7:0] stat_arr_t [NUM_STAT];
  localparam int ST_REG = 0, ST_VOLT_A = 1, ST_VOLT_B = 2, ST_DIODE = 3, ST_THR = 4, ST_GPI = 5, ST_FAN = 6;
  localparam stat_arr_t STAT_OFS   = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4e, 8'h4f};
  localparam stat_arr_t STAT_VALID = '{8'h10, 8'h47, 8'hf1, 8'hdb, 8'hff, 8'hff, 8'h0f};
  localparam stat_arr_t STAT_SUM   = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'hff, 8'hff};
  localparam stat_arr_t S1_STAR    = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f};
  localparam stat_arr_t S3_FIX     = '{8'h10, 8'h47, 8'h41, 8'h18, 8'hff, 8'h00, 8'h00};
  localparam stat_arr_t S3_STAR    = '{8'h00, 8'h00, 8'h30, 8'hc3, 8'h00, 8'hff, 8'h0f};
  localparam stat_arr_t S45_FIX    = '{8'h10, 8'h47, 8'h41, 8'h18, 8'hff, 8'h00, 8'h0f};
  localparam stat_arr_t S45_STAR   = '{8'h00, 8'h00, 8'h30, 8'hc3, 8'h00, 8'hff, 8'h00};
  localparam int REG_HOT_BIT = 4;
  // value registers
  localparam logic [7:0] OFS_Z1B_TEMP = 8'h06, OFS_Z2B_TEMP = 8'h07, OFS_Z1B_FILT = 8'h08, OFS_Z2B_FILT = 8'h09;
  localparam logic [7:0] OFS_Z1A_TEMP = 8'h50, OFS_Z2A_TEMP = 8'h51, OFS_Z3_TEMP = 8'h52, OFS_Z4_TEMP = 8'h53;
  localparam logic [7:0] OFS_Z1A_FILT = 8'h54, OFS_Z2A_FILT = 8'h55;
  localparam logic [7:0] OFS_CUR_THR = 8'h67, OFS_AVG_THR = 8'h68, OFS_GPI_LIVE = 8'h6b;
  localparam int NUM_VOLT = 9;
  typedef logic [7:0] volt_arr_t [NUM_VOLT];
  localparam volt_arr_t VOLT_OFS = '{8'h56, 8'h57, 8'h58, 8'h5c, 8'h5e, 8'h62, 8'h63, 8'h64, 8'h65};
  localparam int VOLT_ZONE4_SRC = 7;
  localparam logic [7:0] TEMP_FAULT_VAL = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;
  // throttle histogram edges in 1/256 steps
  localparam logic [7:0] BIN_12P5 = 8'h20, BIN_25 = 8'h40, BIN_50 = 8'h80, BIN_75 = 8'hc0;
  localparam logic [7:0] THR_FULL_VAL = 8'hff, THR_MIN_VAL = 8'h01;
  // types
  typedef enum logic [1:0] {SLEEP_S0, SLEEP_S1, SLEEP_S3, SLEEP_S45} sleep_t;
  typedef enum logic [3:0] {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
                            BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RACK} bus_state_t;
  typedef struct packed {
    logic [4:0] voltage_limit;   // voltage inputs 1..5 out of window
    logic [3:0] analog_limit;    // analog inputs 13..16 out of window
    logic [3:0] diode_fault;     // 2a, 1a, 2b, 1b
    logic       core_mismatch;
    logic [3:0] fan_slow;
    logic       vid_legacy;
    logic [7:0] gpi_mask;
    logic [7:0] throttle_limit;
    sleep_t     sleep_state;
    logic       star_en;
    logic       zone4_from_analog;
  } monitor_t;
  typedef struct packed {
    logic [7:0]       z1b, z2b, z1a, z2a, z3;
    logic [7:0]       f1b, f2b, f1a, f2a;
    logic [8:0][7:0]  volt;
  } readings_t;
  typedef struct packed {
    logic       scl, sda, reg_hot, general_input8, throttle_n;
    logic [7:0] gpio;
  } pins_t;
endpackage
`default_nettype wire

/* rtl/hw_monitor_host_regs.sv */
// host error status and value register bank behind a two-wire management bus
`timescale 1ns/1ns
`default_nettype none
module hw_monitor_host_regs
  import hw_monitor_pkg::*;
#(
  parameter int         THR_TICK_LOG2 = THR_TICK_LOG2_DEF,
  parameter logic [6:0] SLAVE_ADDR    = SLAVE_ADDR_DEF
) (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESET_I,
  // two-wire management bus
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output var  logic       SDA_O,
  output var  logic       SDA_OE_O,
  // device pins
  input  wire logic       REGULATOR_HOT_I,
  input  wire logic       GENERAL_INPUT8_I,
  input  wire logic       PROCESSOR_THROTTLE_N_I,
  input  wire logic [7:0] GPIO_I,
  // internal monitor logic
  input  wire monitor_t   MONITOR_I,
  input  wire readings_t  READINGS_I,
  // summary
  output var  logic       HOST_SUMMARY_ERR_O
);
  localparam int CW = 8 + THR_TICK_LOG2;

  // pin synchronisers
  pins_t       sync1_reg, sync2_reg, prev_reg;
  wire pins_t  pins_raw = '{SCL_I, SDA_I, REGULATOR_HOT_I, GENERAL_INPUT8_I, PROCESSOR_THROTTLE_N_I, GPIO_I};
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1_reg <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'hff};
      sync2_reg <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'hff};
      prev_reg  <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'hff};
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // bus line conditions, seen on the system clock
  wire logic scl_rise  = sync2_reg.scl && !prev_reg.scl;
  wire logic scl_fall  = !sync2_reg.scl && prev_reg.scl;
  wire logic start_det = sync2_reg.scl && prev_reg.scl && prev_reg.sda && !sync2_reg.sda;
  wire logic stop_det  = sync2_reg.scl && prev_reg.scl && !prev_reg.sda && sync2_reg.sda;

  // bus slave state
  bus_state_t  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic        oe_reg, oe_next;
  logic        rw_reg, rw_next;
  logic        mack_reg, mack_next;
  logic        sda_drive_reg;
  logic        wr_stb;
  logic [7:0]  rd_data;

  // register bank state
  logic [7:0]  stat_reg [NUM_STAT];
  logic [7:0]  stat_next [NUM_STAT];
  logic [7:0]  cond [NUM_STAT];
  logic [7:0]  raw_evt [NUM_STAT];
  logic [NUM_STAT-1:0] sum_bits;
  logic [7:0]  zone4_reg, cur_reg, avg_reg, gpi_live_reg;
  logic [CW-1:0] cyc_reg;
  logic [CW:0]   act_reg;
  logic        summary_reg;

  // sleep masking per status register
  // state passed in, so a continuous caller follows sleep changes too
  function automatic logic [7:0] sleep_mask(input int i, input sleep_t st, input logic star_on);
    logic [7:0] star;
    star = {8{star_on}};
    unique case (st)
      SLEEP_S0:  sleep_mask = 8'h00;
      SLEEP_S1:  sleep_mask = S1_STAR[i] & star;
      SLEEP_S3:  sleep_mask = S3_FIX[i] | (S3_STAR[i] & star);
      SLEEP_S45: sleep_mask = S45_FIX[i] | (S45_STAR[i] & star);
    endcase
  endfunction

  // zone temperature with diode fault substitution
  function automatic logic [7:0] zone_temp(input logic [7:0] t, input logic fault);
    zone_temp = fault ? TEMP_FAULT_VAL : t;
  endfunction

  // read multiplexer; unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    read_mux = 8'h00;
    for (int i = 0; i < NUM_STAT; i++) begin
      if (a == STAT_OFS[i]) read_mux = stat_reg[i];
    end
    for (int v = 0; v < NUM_VOLT; v++) begin
      if (a == VOLT_OFS[v]) read_mux = READINGS_I.volt[v];
    end
    unique case (a)
      OFS_Z1B_TEMP: read_mux = zone_temp(READINGS_I.z1b, MONITOR_I.diode_fault[0]);
      OFS_Z2B_TEMP: read_mux = zone_temp(READINGS_I.z2b, MONITOR_I.diode_fault[1]);
      OFS_Z1A_TEMP: read_mux = zone_temp(READINGS_I.z1a, MONITOR_I.diode_fault[2]);
      OFS_Z2A_TEMP: read_mux = zone_temp(READINGS_I.z2a, MONITOR_I.diode_fault[3]);
      OFS_Z3_TEMP:  read_mux = READINGS_I.z3;
      OFS_Z4_TEMP:  read_mux = MONITOR_I.zone4_from_analog ? READINGS_I.volt[VOLT_ZONE4_SRC] : zone4_reg;
      OFS_Z1B_FILT: read_mux = READINGS_I.f1b;
      OFS_Z2B_FILT: read_mux = READINGS_I.f2b;
      OFS_Z1A_FILT: read_mux = READINGS_I.f1a;
      OFS_Z2A_FILT: read_mux = READINGS_I.f2a;
      OFS_CUR_THR:  read_mux = cur_reg;
      OFS_AVG_THR:  read_mux = avg_reg;
      OFS_GPI_LIVE: read_mux = gpi_live_reg;
      default:      ;
    endcase
  endfunction

  // registered every clock so each mux source is followed; settled long before the next scl fall
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) rd_data <= REG_RESET;
    else         rd_data <= read_mux(ptr_reg);
  end

  // bus slave next state: bits shift in on scl rise, sda changes on scl fall
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    rw_next    = rw_reg;
    mack_next  = mack_reg;
    wr_stb     = 1'b0;
    if (start_det) begin
      state_next = BUS_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_det) begin
      state_next = BUS_IDLE;
      oe_next    = 1'b0;
    end else if (scl_rise) begin
      cnt_next  = cnt_reg + 4'h1;
      mack_next = !sync2_reg.sda;
      if (state_reg == BUS_ADDR || state_reg == BUS_CMD || state_reg == BUS_WDATA) begin
        shift_next = {shift_reg[6:0], sync2_reg.sda};
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        BUS_ADDR: begin
          if (cnt_reg == BYTE_BITS) begin
            state_next = (shift_reg[7:1] == SLAVE_ADDR) ? BUS_ADDR_ACK : BUS_IDLE;
            oe_next    = (shift_reg[7:1] == SLAVE_ADDR);
            rw_next    = shift_reg[0];
          end
        end
        BUS_ADDR_ACK, BUS_RACK: begin
          cnt_next = 4'h0;
          if (rw_reg && (state_reg == BUS_ADDR_ACK || mack_reg)) begin
            shift_next = rd_data;
            oe_next    = !rd_data[7];
            ptr_next   = ptr_reg + 8'h01;
            state_next = BUS_RDATA;
          end else begin
            oe_next    = 1'b0;
            state_next = rw_reg ? BUS_IDLE : BUS_CMD;
          end
        end
        BUS_CMD: begin
          if (cnt_reg == BYTE_BITS) begin
            ptr_next   = shift_reg;
            oe_next    = 1'b1;
            state_next = BUS_CMD_ACK;
          end
        end
        BUS_WDATA: begin
          if (cnt_reg == BYTE_BITS) begin
            wr_stb     = 1'b1;
            oe_next    = 1'b1;
            state_next = BUS_WDATA_ACK;
          end
        end
        BUS_CMD_ACK, BUS_WDATA_ACK: begin
          oe_next    = 1'b0;
          cnt_next   = 4'h0;
          ptr_next   = (state_reg == BUS_WDATA_ACK) ? ptr_reg + 8'h01 : ptr_reg;
          state_next = BUS_WDATA;
        end
        BUS_RDATA: begin
          if (cnt_reg == BYTE_BITS) begin
            oe_next    = 1'b0;
            state_next = BUS_RACK;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = !shift_reg[6];
          end
        end
        BUS_IDLE: ;
      endcase
    end
  end

  // bus slave registers
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg     <= BUS_IDLE;
      cnt_reg       <= 4'h0;
      shift_reg     <= REG_RESET;
      ptr_reg       <= REG_RESET;
      oe_reg        <= 1'b0;
      rw_reg        <= 1'b0;
      mack_reg      <= 1'b0;
      sda_drive_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      shift_reg     <= shift_next;
      ptr_reg       <= ptr_next;
      oe_reg        <= oe_next;
      rw_reg        <= rw_next;
      mack_reg      <= mack_next;
      sda_drive_reg <= 1'b0;      // open drain: only ever pulls low
    end
  end

  assign SDA_O    = sda_drive_reg;
  assign SDA_OE_O = oe_reg;

  // throttle capture: active cycles over an interval of 256 ticks
  wire logic        thr_active  = !sync2_reg.throttle_n;
  wire logic        thr_restart = wr_stb && ptr_reg == OFS_CUR_THR;
  wire logic        thr_done    = (cyc_reg == '1) && !thr_restart;
  wire logic [CW:0] act_total   = act_reg + (CW+1)'(thr_active);
  wire logic [8:0]  frac9       = 9'(act_total >> THR_TICK_LOG2);
  wire logic        thr_any     = act_total != '0;
  wire logic        thr_full    = frac9[8];
  // smallest nonzero time still reads one
  wire logic [7:0]  cur_val     = thr_full ? THR_FULL_VAL :
                                  (thr_any && frac9 == 9'h000) ? THR_MIN_VAL : frac9[7:0];
  wire logic [8:0]  avg_sum     = 9'(avg_reg) + 9'(cur_val);
  wire logic [7:0]  avg_half    = avg_sum[8:1];
  wire logic [7:0]  avg_val     = (avg_sum != 9'h000 && avg_half == 8'h00) ? THR_MIN_VAL : avg_half;
  // histogram bits from the new fraction, raised only at interval end
  wire logic [7:0]  thr_bins    = {cur_val > MONITOR_I.throttle_limit,
                                   thr_full,
                                   !thr_full && cur_val >= BIN_75,
                                   cur_val >= BIN_50 && cur_val < BIN_75,
                                   cur_val >= BIN_25 && cur_val < BIN_50,
                                   cur_val >= BIN_12P5 && cur_val < BIN_25,
                                   thr_any && cur_val < BIN_12P5,
                                   thr_any};

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      cyc_reg <= '0;
      act_reg <= '0;
      cur_reg <= REG_RESET;
      avg_reg <= REG_RESET;
    end else if (thr_restart) begin
      cyc_reg <= '0;                      // contents stay, capture restarts
      act_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + CW'(1);
      act_reg <= thr_done ? '0 : act_total;
      if (thr_done) begin
        cur_reg <= cur_val;
        avg_reg <= avg_val;
      end
    end
  end

  // raw events per status register
  assign raw_evt[ST_REG]    = 8'(sync2_reg.reg_hot) << REG_HOT_BIT;
  assign raw_evt[ST_VOLT_A] = {1'b0, MONITOR_I.voltage_limit[3], 3'b000, MONITOR_I.voltage_limit[2:0]};
  assign raw_evt[ST_VOLT_B] = {MONITOR_I.analog_limit, 3'b000, MONITOR_I.voltage_limit[4]};
  assign raw_evt[ST_DIODE]  = {MONITOR_I.diode_fault[3:2], 1'b0, MONITOR_I.core_mismatch,
                               sync2_reg.general_input8 && MONITOR_I.vid_legacy, 1'b0,
                               MONITOR_I.diode_fault[1:0]};
  assign raw_evt[ST_THR]    = thr_done ? thr_bins : 8'h00;
  assign raw_evt[ST_GPI]    = ~sync2_reg.gpio & ~MONITOR_I.gpi_mask;
  assign raw_evt[ST_FAN]    = {4'h0, MONITOR_I.fan_slow};

  // sticky write-one-to-clear status; a live condition beats the clear
  for (genvar i = 0; i < NUM_STAT; i++) begin : g_stat
    wire logic [7:0] clr = (wr_stb && ptr_reg == STAT_OFS[i]) ? shift_reg : 8'h00;
    assign cond[i]      = raw_evt[i] & ~sleep_mask(i, MONITOR_I.sleep_state, MONITOR_I.star_en);
    assign stat_next[i] = ((stat_reg[i] & ~(clr & ~cond[i])) | cond[i]) & STAT_VALID[i];
    assign sum_bits[i]  = |(stat_reg[i] & STAT_SUM[i]);
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) stat_reg[i] <= REG_RESET;
      else         stat_reg[i] <= stat_next[i];
    end
  end

  // zone4 store, live input state and summary flag
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      zone4_reg    <= REG_RESET;
      gpi_live_reg <= REG_RESET;
      summary_reg  <= 1'b0;
    end else begin
      if (wr_stb && ptr_reg == OFS_Z4_TEMP) zone4_reg <= shift_reg;
      gpi_live_reg <= ~sync2_reg.gpio;
      summary_reg  <= |sum_bits;
    end
  end

  assign HOST_SUMMARY_ERR_O = summary_reg;

  // checks
  reg_hot_set_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    sync2_reg.reg_hot && MONITOR_I.sleep_state == SLEEP_S0 |=> stat_reg[ST_REG][REG_HOT_BIT])
    else $error("regulator hot bit not set");
  volt_sticky_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    stat_reg[ST_VOLT_A][0] && cond[ST_VOLT_A][0] |=> stat_reg[ST_VOLT_A][0])
    else $error("status bit cleared while condition present");
  w1c_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_stb && ptr_reg == STAT_OFS[ST_FAN] && shift_reg[0] && !cond[ST_FAN][0] |=> !stat_reg[ST_FAN][0])
    else $error("write one did not clear fan bit");
  reserved_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (stat_reg[ST_DIODE] & ~STAT_VALID[ST_DIODE]) == 8'h00 && (stat_reg[ST_FAN] & ~STAT_VALID[ST_FAN]) == 8'h00)
    else $error("reserved status bit set");
  gpi_masked_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !stat_reg[ST_GPI][0] && MONITOR_I.gpi_mask[0] |=> !stat_reg[ST_GPI][0])
    else $error("masked general input set error");
  sleep_mask_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    MONITOR_I.sleep_state == SLEEP_S3 && !stat_reg[ST_THR][0] |=> !stat_reg[ST_THR][0])
    else $error("throttle event not suppressed in sleep");
  thr_avg_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    thr_done |=> avg_reg == ((9'(cur_reg) + 9'($past(avg_reg)) == 9'h001) ? 8'h01 :
                            8'((9'(cur_reg) + 9'($past(avg_reg))) >> 1)))
    else $error("average throttle wrong");
  thr_min_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    thr_done && act_total != '0 |=> cur_reg != 8'h00 ##0 stat_reg[ST_THR][0] || MONITOR_I.sleep_state != SLEEP_S0)
    else $error("nonzero throttle read as zero");
  thr_restart_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    thr_restart |=> cyc_reg == '0 && $stable(cur_reg) ##1 cyc_reg == CW'(1))
    else $error("throttle write did not restart capture");
  summary_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    stat_reg[ST_REG] == 8'h00 && stat_reg[ST_VOLT_A] == 8'h00 && stat_reg[ST_VOLT_B] == 8'h00 &&
    stat_reg[ST_DIODE] == 8'h00 && stat_reg[ST_GPI] == 8'h00 && stat_reg[ST_FAN] == 8'h00 &&
    !stat_reg[ST_THR][7] |=> !summary_reg)
    else $error("histogram bit reached summary");
  limit_summary_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    stat_reg[ST_THR][7] |=> summary_reg)
    else $error("throttle limit bit missed summary");
  zone4_wr_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_stb && ptr_reg == OFS_Z4_TEMP |=> zone4_reg == $past(shift_reg))
    else $error("zone4 write lost");
  wr_cover_c:   cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) wr_stb);
  rd_cover_c:   cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) state_reg == BUS_RDATA && scl_fall);
  thr_cover_c:  cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) thr_done && thr_any);
  clr_cover_c:  cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) $fell(stat_reg[ST_FAN][0]));
endmodule // hw_monitor_host_regs
`default_nettype wire

/* verif/host_bus_model.sv */
// host side model of the two-wire management bus
`timescale 1ns/1ns
`default_nettype none
module host_bus_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2c
) (
  // clock and resolved data wire
  input  wire logic clk_i,
  input  wire logic sda_i,
  // host drive, 1 releases the wire to its pull-up
  output var  logic scl_o,
  output var  logic sda_o
);
  logic ack_bit = 1'b1;
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // each change lands just after an edge and stands n cycles
  task automatic step(input logic c, input logic d, input int n);
    scl_o <= c;
    sda_o <= d;
    hold(n);
  endtask
  // data moves only mid-low, well clear of the synchronised clock edges
  task automatic put_bit(input logic b);
    step(1'b0, sda_o, 4);
    step(1'b0, b, 4);
    step(1'b1, b, 8);
  endtask
  task automatic get_bit(output logic b);
    step(1'b0, sda_o, 4);
    step(1'b0, 1'b1, 4);
    step(1'b1, 1'b1, 4);
    b = sda_i;
    hold(4);
  endtask
  // s high gives a start or repeated start, s low a stop
  task automatic frame(input logic s);
    step(1'b0, sda_o, 4);
    step(1'b0, s, 4);
    step(1'b1, s, 8);
    step(1'b1, ~s, 8);
  endtask
  task automatic put_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack_bit);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    frame(1'b1);
    put_byte({DEV_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    frame(1'b0);
  endtask
  // single byte read, closed by a not-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    frame(1'b1);
    put_byte({DEV_ADDR, 1'b0});
    put_byte(a);
    frame(1'b1);
    put_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    frame(1'b0);
  endtask
endmodule // host_bus_model
`default_nettype wire

/* verif/hw_monitor_host_regs_tb_top.sv */
// self-checking bench for the host error and value register bank
`timescale 1ns/1ns
`default_nettype none
module hw_monitor_host_regs_tb_top
  import hw_monitor_pkg::*;
;
  logic       clk = 1'b0, rst = 1'b1, hot = 1'b0, gin8 = 1'b0, thr_n = 1'b1, tog = 1'b0;
  logic [7:0] gpio = 8'hff;
  monitor_t   mon = '0;
  readings_t  vals = '0;
  logic       scl, sda_h, sda_oe, sda_lo, summ;
  int         err_total = 0, total_checks = 0;
  // open drain: an enabled device pin ANDs its own output level with the host drive
  wire logic  sda_w = sda_oe ? (sda_lo & sda_h) : sda_h;
  always #5 clk = ~clk;
  // toggling every cycle gives exactly half of any throttle interval active
  always @(posedge clk) if (tog) thr_n <= ~thr_n;
  hw_monitor_host_regs #(.THR_TICK_LOG2(1), .SLAVE_ADDR(SLAVE_ADDR_DEF)) dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_lo), .SDA_OE_O(sda_oe),
    .REGULATOR_HOT_I(hot), .GENERAL_INPUT8_I(gin8), .PROCESSOR_THROTTLE_N_I(thr_n), .GPIO_I(gpio),
    .MONITOR_I(mon), .READINGS_I(vals), .HOST_SUMMARY_ERR_O(summ));
  host_bus_model #(.DEV_ADDR(SLAVE_ADDR_DEF)) host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // every error source except throttling live at once, then sticky and clear behaviour
  task automatic t_set_clear();
    stat_arr_t exp = '{8'h10, 8'h47, 8'hf1, 8'hdb, 8'h00, 8'hff, 8'h0f};
    for (int i = 0; i < NUM_STAT; i++) rchk(STAT_OFS[i], 8'h00);
    mon <= '{voltage_limit: 5'h1f, analog_limit: 4'hf, diode_fault: 4'hf, core_mismatch: 1'b1,
             fan_slow: 4'hf, vid_legacy: 1'b1, sleep_state: SLEEP_S0, default: '0};
    hot <= 1'b1;
    gin8 <= 1'b1;
    gpio <= 8'h00;
    for (int i = 0; i < NUM_STAT; i++) rchk(STAT_OFS[i], exp[i]);
    chk({7'h00, summ}, 8'h01);
    host.wr(STAT_OFS[ST_FAN], 8'hff);
    rchk(STAT_OFS[ST_FAN], 8'h0f);
    mon <= '0;
    hot <= 1'b0;
    gin8 <= 1'b0;
    gpio <= 8'hff;
    host.wr(STAT_OFS[ST_VOLT_A], 8'h00);
    rchk(STAT_OFS[ST_VOLT_A], 8'h47);
    host.wr(STAT_OFS[ST_FAN], 8'h01);
    rchk(STAT_OFS[ST_FAN], 8'h0e);
    for (int i = 0; i < NUM_STAT; i++) begin
      host.wr(STAT_OFS[i], 8'hff);
      rchk(STAT_OFS[i], 8'h00);
    end
    chk({7'h00, summ}, 8'h00);
  endtask
  // input mask, live input state and fixed versus starred sleep masks
  task automatic t_mask();
    mon <= '{gpi_mask: 8'h0f, sleep_state: SLEEP_S3, voltage_limit: 5'h11, analog_limit: 4'h1, default: '0};
    gpio <= 8'h5a;
    rchk(OFS_GPI_LIVE, 8'ha5);
    rchk(STAT_OFS[ST_GPI], 8'ha0);
    rchk(STAT_OFS[ST_VOLT_A], 8'h00);
    rchk(STAT_OFS[ST_VOLT_B], 8'h10);
    // starred masks in light sleep only with star enable, fixed fan mask in deep sleep
    mon <= '{gpi_mask: 8'h0f, sleep_state: SLEEP_S1, star_en: 1'b1, fan_slow: 4'h3, default: '0};
    host.wr(STAT_OFS[ST_GPI], 8'hff);
    rchk(STAT_OFS[ST_GPI], 8'h00);
    rchk(STAT_OFS[ST_FAN], 8'h00);
    mon <= '{sleep_state: SLEEP_S45, fan_slow: 4'h3, default: '0};
    rchk(STAT_OFS[ST_FAN], 8'h00);
    rchk(STAT_OFS[ST_GPI], 8'ha5);
    mon <= '0;
    gpio <= 8'hff;
    host.wr(STAT_OFS[ST_VOLT_B], 8'hff);
    host.wr(STAT_OFS[ST_GPI], 8'hff);
  endtask
  // readouts, zone 4 source, diode fault value and refused accesses
  task automatic t_values();
    for (int i = 0; i < NUM_VOLT; i++) vals.volt[i] <= 8'hc0 + 8'(i);
    vals.z2a <= 8'h2d;
    vals.z1a <= 8'h3c;
    vals.f1a <= 8'h31;
    vals.z1b <= 8'h4b;
    vals.z2b <= 8'h1e;
    vals.z3  <= 8'h25;
    vals.f1b <= 8'h44;
    vals.f2b <= 8'h19;
    vals.f2a <= 8'h2a;
    mon <= '{diode_fault: 4'h5, zone4_from_analog: 1'b1, sleep_state: SLEEP_S0, default: '0};
    for (int i = 0; i < NUM_VOLT; i++) rchk(VOLT_OFS[i], 8'hc0 + 8'(i));
    rchk(OFS_Z1A_TEMP, 8'h80);
    rchk(OFS_Z2A_TEMP, 8'h2d);
    rchk(OFS_Z1A_FILT, 8'h31);
    rchk(OFS_Z4_TEMP, 8'hc7);
    rchk(OFS_Z1B_TEMP, 8'h80);
    rchk(OFS_Z2B_TEMP, 8'h1e);
    rchk(OFS_Z3_TEMP, 8'h25);
    rchk(OFS_Z1B_FILT, 8'h44);
    rchk(OFS_Z2B_FILT, 8'h19);
    rchk(OFS_Z2A_FILT, 8'h2a);
    mon <= '0;
    host.wr(OFS_Z4_TEMP, 8'h5a);
    rchk(OFS_Z4_TEMP, 8'h5a);
    host.wr(STAT_OFS[ST_DIODE], 8'hff);
    rchk(8'h30, 8'h00);
    host.frame(1'b1);
    host.put_byte({~SLAVE_ADDR_DEF, 1'b0});
    chk({7'h00, host.ack_bit}, 8'h01);
    host.frame(1'b0);
  endtask
  // half then full throttling; the partial interval at each change is cleared away
  task automatic t_throttle();
    mon.throttle_limit <= 8'h80;
    tog <= 1'b1;
    host.hold(1100);
    host.wr(STAT_OFS[ST_THR], 8'hff);
    host.hold(1100);
    rchk(OFS_CUR_THR, 8'h80);
    rchk(STAT_OFS[ST_THR], 8'h11);
    chk({7'h00, summ}, 8'h00);
    host.wr(OFS_CUR_THR, 8'h00);
    rchk(OFS_CUR_THR, 8'h80);
    tog <= 1'b0;
    host.hold(1);
    thr_n <= 1'b0;
    host.hold(5000);
    host.wr(STAT_OFS[ST_THR], 8'hff);
    host.hold(1100);
    rchk(OFS_CUR_THR, 8'hff);
    rchk(OFS_AVG_THR, 8'hfe);
    rchk(STAT_OFS[ST_THR], 8'hc1);
    chk({7'h00, summ}, 8'h01);
  endtask
  initial begin
    host.hold(2);
    rst <= 1'b0;
    host.hold(4);
    t_set_clear();
    t_mask();
    t_values();
    t_throttle();
    wrap_up();
  end
  // watchdog well beyond the expected length of the run
  initial begin
    host.hold(95000);
    err_total++;
    wrap_up();
  end
endmodule // hw_monitor_host_regs_tb_top
`default_nettype wire
